/* test/apdc_top_asserts.sv */
// checker: port properties of the quadrant control bank
`timescale 1ns/1ps
`default_nettype none
module apdc_top_asserts
  import apdc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register port
  input wire logic [APDC_ADDR_W-1:0] i_addr,
  input wire logic [APDC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [APDC_DATA_W-1:0] o_rdata,
  // controls
  input wire apdc_ctrl_t o_ctrl
);
  // ==========================================================================
  // one domain; the reset check overrides the default disable
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_pwr_write: assert property (i_wr && i_addr == APDC_OFS_PWR |=>
    o_ctrl.domain_power_on == $past(i_wdata[3:0])) else $error("power write lost");
  a_ram_write: assert property (i_wr && i_addr == APDC_OFS_RAM |=>
    o_ctrl.memory_power_on == $past(i_wdata[3:0])) else $error("memory write lost");
  a_iso_write: assert property (i_wr && i_addr == APDC_OFS_ISO |=>
    o_ctrl.isolate == $past(i_wdata[3:0])) else $error("isolation write lost");
  a_rst_write: assert property (i_wr && i_addr == APDC_OFS_RST |=>
    o_ctrl.domain_reset_req == $past(i_wdata[3:0])) else $error("reset write lost");
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=> o_ctrl == '0 && o_rdata == '0)
    else $error("not cleared by reset");
  a_iso_read: assert property (i_rd && i_addr == APDC_OFS_ISO |=>
    o_rdata == {28'h0, $past(o_ctrl.isolate)}) else $error("isolation read wrong");
  a_hole_read: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == '0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* test/test_accel_power_domain_ctrl.sv */
// testbench: register access, reset and refusal scenarios
`timescale 1ns/1ps
`default_nettype none
module test_accel_power_domain_ctrl;
  import apdc_pkg::*;
  logic i_clk_sys, i_rst, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  apdc_ctrl_t o_ctrl;
  int n_mismatch, n_checks;
  apdc_top DUT (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ctrl);
  // ==========================================================================
  // 200 MHz clock
  initial begin
    i_clk_sys = 0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus cycle, driven at the edge and held a full cycle
  task automatic op(input logic w, r, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    op(1, 0, a, d);
    op(0, 0, a, d);
    #1;
  endtask
  // read data only stands one cycle, so sample right after it lands
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    op(0, 1, a, '0);
    op(0, 0, a, '0);
    #1 chk(o_rdata, e);
  endtask
  task automatic t_fields;
    logic [15:0] e;
    e = '0;
    for (int i = 0; i < 4; i++) begin
      e[15-4*i -: 4] = 4'h3 << i;
      wr(4'(4*i), {28'hFFFFFFF, e[15-4*i -: 4]});
      chk(o_ctrl, e);
    end
    for (int i = 0; i < 4; i++) rd(4'(4*i), {28'h0, e[15-4*i -: 4]});
    wr(APDC_OFS_RST, '0);
    chk(o_ctrl, 32'h36C0);
  endtask
  // a hole in the map must neither store nor answer
  task automatic t_hole;
    wr(4'h1, 32'hF);
    chk(o_ctrl, 32'h36C0);
    rd(4'h1, '0);
  endtask
  task automatic t_midreset;
    i_rst <= 1;
    @(posedge i_clk_sys);
    #1 chk(o_ctrl, '0);
    chk(o_rdata, '0);
    @(posedge i_clk_sys);
    i_rst <= 0;
    rd(APDC_OFS_ISO, '0);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'h4, 36'h0};
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 0;
    chk(o_ctrl, '0);
    t_fields;
    t_hole;
    t_midreset;
    complete_run;
  end
  // hang guard
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule
bind apdc_top apdc_top_asserts u_chk (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ctrl);
`default_nettype wire

/* verilog/apdc_ctrl_reg.sv */
// one 4-bit read/write control register with reset-to-zero
`timescale 1ns/1ps
`default_nettype none
module apdc_ctrl_reg #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // write side
  input wire logic i_we,
  input wire logic [WIDTH-1:0] i_wdata,
  // stored value
  output logic [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  // ==========================================================================
  // next value: load on write, else hold
  always_comb begin
    value_d = value_q;
    if (i_we) begin
      value_d = i_wdata;
    end
  end

  // any reset source arrives merged onto i_rst
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      value_q <= '0; // R5
    end else begin
      value_q <= value_d;
    end
  end

  assign o_value = value_q;
endmodule
`default_nettype wire

/* verilog/apdc_pkg.sv */
// package: register map, field layout and reset values for the accelerator power domain bank
`default_nettype none
package apdc_pkg;
  // ==========================================================================
  // sizes
  localparam int APDC_NUM_QUAD = 4;
  localparam int APDC_ADDR_W = 4;
  localparam int APDC_DATA_W = 32;
  // ==========================================================================
  // register byte offsets
  localparam logic [APDC_ADDR_W-1:0] APDC_OFS_PWR = 4'h0;
  localparam logic [APDC_ADDR_W-1:0] APDC_OFS_RAM = 4'h4;
  localparam logic [APDC_ADDR_W-1:0] APDC_OFS_ISO = 4'h8;
  localparam logic [APDC_ADDR_W-1:0] APDC_OFS_RST = 4'hC;
  // ==========================================================================
  // field layout and reset values
  localparam int APDC_FLD_LSB = 0;
  localparam logic [APDC_NUM_QUAD-1:0] APDC_FLD_RESET = 4'h0;
  localparam logic [APDC_DATA_W-1:0] APDC_RD_UNMAPPED = 32'h0000_0000;

  // one control bit per quadrant, carried together
  typedef struct packed {
    logic [APDC_NUM_QUAD-1:0] domain_power_on;
    logic [APDC_NUM_QUAD-1:0] memory_power_on;
    logic [APDC_NUM_QUAD-1:0] isolate;
    logic [APDC_NUM_QUAD-1:0] domain_reset_req;
  } apdc_ctrl_t;

  // plain register port request
  typedef struct packed {
    logic [APDC_ADDR_W-1:0] addr;
    logic [APDC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } apdc_req_t;
endpackage
`default_nettype wire

/* verilog/apdc_top.sv */
// top: register bank driving power, memory, isolation and reset controls of four quadrants
//
// Summary of operation
// R1 - one read/write domain power enable bit per quadrant; 1 is on, 0 off.
// R2 - one read/write memory power enable bit per quadrant in second register.
// R3 - one read/write isolation bit per quadrant; 1 isolates, 0 releases.
// R4 - writing 1 to a reset bit starts that quadrant's domain reset.
// R5 - every field clears to zero on any reset source.
// R6 - bits 31 to 4 read zero, ignore writes; word access only.
`timescale 1ns/1ps
`default_nettype none
module apdc_top
  import apdc_pkg::*;
#(
  parameter int NUM_QUAD = apdc_pkg::APDC_NUM_QUAD
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register port
  input wire logic [apdc_pkg::APDC_ADDR_W-1:0] i_addr,
  input wire logic [apdc_pkg::APDC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [apdc_pkg::APDC_DATA_W-1:0] o_rdata,
  // quadrant controls
  output apdc_pkg::apdc_ctrl_t o_ctrl
);
  import apdc_pkg::*;

  // ==========================================================================
  // address decode
  logic we_pwr;
  logic we_ram;
  logic we_iso;
  logic we_rst;
  // only the low nibble is written; the upper bits have no storage
  logic [APDC_NUM_QUAD-1:0] wr_field;

  assign wr_field = i_wdata[APDC_FLD_LSB +: APDC_NUM_QUAD]; // R6
  assign we_pwr = i_wr && (i_addr == APDC_OFS_PWR);
  assign we_ram = i_wr && (i_addr == APDC_OFS_RAM);
  assign we_iso = i_wr && (i_addr == APDC_OFS_ISO);
  assign we_rst = i_wr && (i_addr == APDC_OFS_RST);

  // ==========================================================================
  // control registers
  logic [APDC_NUM_QUAD-1:0] pwr_q;
  logic [APDC_NUM_QUAD-1:0] ram_q;
  logic [APDC_NUM_QUAD-1:0] iso_q;
  logic [APDC_NUM_QUAD-1:0] rst_q;

  // domain power enables
  apdc_ctrl_reg #(.WIDTH(APDC_NUM_QUAD)) u_pwr ( // R1
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_pwr),
    .i_wdata(wr_field),
    .o_value(pwr_q)
  );

  // memory power enables
  apdc_ctrl_reg #(.WIDTH(APDC_NUM_QUAD)) u_ram ( // R2
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_ram),
    .i_wdata(wr_field),
    .o_value(ram_q)
  );

  // isolation controls
  apdc_ctrl_reg #(.WIDTH(APDC_NUM_QUAD)) u_iso ( // R3
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_iso),
    .i_wdata(wr_field),
    .o_value(iso_q)
  );

  // domain reset requests; level held until software writes 0
  apdc_ctrl_reg #(.WIDTH(APDC_NUM_QUAD)) u_rst ( // R4
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_rst),
    .i_wdata(wr_field),
    .o_value(rst_q)
  );

  // ==========================================================================
  // outputs: controls are register outputs straight to the quadrants
  always_comb begin
    o_ctrl.domain_power_on = pwr_q; // R1
    o_ctrl.memory_power_on = ram_q; // R2
    o_ctrl.isolate = iso_q; // R3
    o_ctrl.domain_reset_req = rst_q; // R4
  end

  // ==========================================================================
  // read path: data valid in the cycle after the strobe only
  logic [APDC_DATA_W-1:0] rdata_q;
  logic [APDC_DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      case (i_addr)
        APDC_OFS_PWR: rdata_d = {28'h0000000, pwr_q}; // R6
        APDC_OFS_RAM: rdata_d = {28'h0000000, ram_q}; // R6
        APDC_OFS_ISO: rdata_d = {28'h0000000, iso_q}; // R6
        APDC_OFS_RST: rdata_d = {28'h0000000, rst_q}; // R6
        default: rdata_d = APDC_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0; // R5
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
endmodule
`default_nettype wire
